// ==== rtl/virtual_scan_hub.v ====
`timescale 1ns/100ps
// Summary of operation
// - TDI bits shift into the selected chain; chain output drives TDO.
// - TAP steered by TMS; all scan logic timed on TCK edges.
// - Optional TRST input resets the TAP state machine.
// - Instruction value selects which data chain sits between TDI and TDO.
// - Instruction register and node frame have shift stage plus holding stage kept stable while shifting; bypass bit has no holding stage.
// - Instruction path code reaches node instruction; data path code reaches node data.
// - Node shifts travel only inside physical data-register scans.
// - Hub decodes TMS itself with its own TAP state machine copy.
// - At most one node holds the active TDI path at a time; none when no valid node address is loaded.
// - Hub controls node shift start/stop and hold/shift transfers.
// - Hub broadcasts decoded state and per-node enables to all nodes.
// - Hub supports up to 255 nodes.
// - Raw hub state is not exported; only decoded indicators.
// - Node instruction return sampled during node instruction capture.
// - Node instruction output loaded and held at node instruction update.
// - Node instruction width configurable 1 to 24 bits.
module virtual_scan_hub #(
    parameter NODES = 4,
    parameter NODE_IW = 4
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire i_trst_n,
    output reg o_tdo,
    input wire [NODES-1:0] i_node_tdo,
    input wire [NODES*NODE_IW-1:0] i_node_instruction_return,
    output reg [NODES*NODE_IW-1:0] o_node_instruction_out,
    output reg [NODES-1:0] o_node_enable,
    output reg o_node_tdi,
    output reg o_tck_rise,
    output reg o_state_cdr,
    output reg o_state_sdr,
    output reg o_state_e1dr,
    output reg o_state_pdr,
    output reg o_state_e2dr,
    output reg o_state_udr,
    output reg o_state_cir,
    output reg o_state_uir
);
    `include "scan_hub_map.vh"
    localparam FW = `NODE_ADDR_W + NODE_IW;

    // Pin synchronisers
    reg [1:0] tck_sync;
    reg [1:0] tms_sync;
    reg [1:0] tdi_sync;
    reg [1:0] trst_sync;
    reg tck_prev;
    wire tck_rise;
    wire tck_fall;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tck_sync <= 2'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h0;
            trst_sync <= 2'h3;
            tck_prev <= 1'b0;
        end
        else
        begin
            tck_sync <= {tck_sync[0], i_tck};
            tms_sync <= {tms_sync[0], i_tms};
            tdi_sync <= {tdi_sync[0], i_tdi};
            trst_sync <= {trst_sync[0], i_trst_n};
            tck_prev <= tck_sync[1];
        end
    end
    assign tck_rise = tck_sync[1] && !tck_prev;
    assign tck_fall = !tck_sync[1] && tck_prev;

    ////////////////////////////////////////////////////////////////////////
    // TAP state machine copy
    reg [3:0] tap;
    reg [3:0] next_tap;

    always @*
    begin
        case (tap)
            `TAP_RESET: next_tap = tms_sync[1] ? `TAP_RESET : `TAP_IDLE;
            `TAP_IDLE: next_tap = tms_sync[1] ? `TAP_SEL_DR : `TAP_IDLE;
            `TAP_SEL_DR: next_tap = tms_sync[1] ? `TAP_SEL_IR : `TAP_CAP_DR;
            `TAP_CAP_DR: next_tap = tms_sync[1] ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_SHIFT_DR: next_tap = tms_sync[1] ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
            `TAP_EXIT1_DR: next_tap = tms_sync[1] ? `TAP_UPD_DR : `TAP_PAUSE_DR;
            `TAP_PAUSE_DR: next_tap = tms_sync[1] ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
            `TAP_EXIT2_DR: next_tap = tms_sync[1] ? `TAP_UPD_DR : `TAP_SHIFT_DR;
            `TAP_UPD_DR: next_tap = tms_sync[1] ? `TAP_SEL_DR : `TAP_IDLE;
            `TAP_SEL_IR: next_tap = tms_sync[1] ? `TAP_RESET : `TAP_CAP_IR;
            `TAP_CAP_IR: next_tap = tms_sync[1] ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_SHIFT_IR: next_tap = tms_sync[1] ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
            `TAP_EXIT1_IR: next_tap = tms_sync[1] ? `TAP_UPD_IR : `TAP_PAUSE_IR;
            `TAP_PAUSE_IR: next_tap = tms_sync[1] ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
            `TAP_EXIT2_IR: next_tap = tms_sync[1] ? `TAP_UPD_IR : `TAP_SHIFT_IR;
            `TAP_UPD_IR: next_tap = tms_sync[1] ? `TAP_SEL_DR : `TAP_IDLE;
            default: next_tap = `TAP_RESET;
        endcase
    end

    // Instruction register: shift and hold stages
    reg [`IR_LEN-1:0] ir_shift;
    reg [`IR_LEN-1:0] ir_hold;
    // Instruction-path frame: {node address, node instruction}
    reg [FW-1:0] frame_shift;
    reg [`NODE_ADDR_W-1:0] active_node;
    reg bypass_bit;
    wire sel_ipath;
    wire sel_dpath;
    wire [`NODE_ADDR_W-1:0] frame_addr;
    wire frame_addr_ok;
    integer n;
    integer m;

    assign sel_ipath = (ir_hold == `INSTRUCTION_PATH_SELECT_CODE);
    assign sel_dpath = (ir_hold == `DATA_PATH_SELECT_CODE);
    assign frame_addr = frame_shift[FW-1:NODE_IW];
    assign frame_addr_ok = (frame_addr != {`NODE_ADDR_W{1'b0}}) &&
        ({24'h00_0000, frame_addr} <= NODES) && (frame_addr <= `NODE_MAX);

    // Node instruction return of the addressed node
    function [NODE_IW-1:0] node_return;
        input [NODES*NODE_IW-1:0] all;
        input [`NODE_ADDR_W-1:0] addr;
        integer k;
        begin
            node_return = {NODE_IW{1'b0}};
            for (k = 0; k < NODES; k = k + 1)
                if (addr == k + 1)
                    node_return = all[k*NODE_IW +: NODE_IW];
        end
    endfunction

    // Scan events go through the buffer: {tdi, tap state}
    wire buf_in_ready;
    wire buf_valid;
    wire [4:0] buf_data;
    wire [3:0] ev_tap;
    wire ev_tdi;
    assign ev_tap = buf_data[3:0];
    assign ev_tdi = buf_data[4];

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tap <= `TAP_RESET;
            ir_shift <= {`IR_LEN{1'b0}};
            ir_hold <= {`IR_LEN{1'b0}};
            frame_shift <= {FW{1'b0}};
            active_node <= {`NODE_ADDR_W{1'b0}};
            o_node_instruction_out <= {NODES*NODE_IW{1'b0}};
            bypass_bit <= 1'b0;
        end
        else if (!trst_sync[1])
        begin
            tap <= `TAP_RESET;
            ir_hold <= {`IR_LEN{1'b0}};
            active_node <= {`NODE_ADDR_W{1'b0}};
        end
        else if (tck_rise && buf_in_ready)
        begin
            tap <= next_tap;
            case (tap)
                `TAP_RESET: ir_hold <= {`IR_LEN{1'b0}};
                `TAP_CAP_IR: ir_shift <= `IR_CAPTURE;
                `TAP_SHIFT_IR: ir_shift <= {tdi_sync[1], ir_shift[`IR_LEN-1:1]};
                `TAP_UPD_IR: ir_hold <= ir_shift;
                `TAP_CAP_DR:
                    if (sel_ipath)
                        frame_shift <= {active_node,
                            node_return(i_node_instruction_return, active_node)};
                `TAP_SHIFT_DR:
                begin
                    bypass_bit <= tdi_sync[1];
                    if (sel_ipath)
                        frame_shift <= {tdi_sync[1], frame_shift[FW-1:1]};
                end
                `TAP_UPD_DR:
                    if (sel_ipath)
                    begin
                        active_node <= frame_addr_ok ? frame_addr : {`NODE_ADDR_W{1'b0}};
                        for (n = 0; n < NODES; n = n + 1)
                            if (frame_addr_ok && frame_addr == n + 1)
                                o_node_instruction_out[n*NODE_IW +: NODE_IW] <=
                                    frame_shift[NODE_IW-1:0];
                    end
                default: ;
            endcase
        end
    end

    stage_buffer #(.WIDTH(5)) u_events (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(tck_rise && trst_sync[1]),
        .o_ready(buf_in_ready),
        .i_data({tdi_sync[1], tap}),
        .o_valid(buf_valid),
        .i_ready(1'b1),
        .o_data(buf_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decoded node-facing state, two clocks after each TCK rise
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_tck_rise <= 1'b0;
            o_node_tdi <= 1'b0;
            o_node_enable <= {NODES{1'b0}};
            o_state_cdr <= 1'b0;
            o_state_sdr <= 1'b0;
            o_state_e1dr <= 1'b0;
            o_state_pdr <= 1'b0;
            o_state_e2dr <= 1'b0;
            o_state_udr <= 1'b0;
            o_state_cir <= 1'b0;
            o_state_uir <= 1'b0;
        end
        else
        begin
            o_tck_rise <= buf_valid;
            if (buf_valid)
            begin
                o_node_tdi <= ev_tdi;
                for (m = 0; m < NODES; m = m + 1)
                    o_node_enable[m] <= (active_node == m + 1);
                // Data-path states, only while the data path code is loaded
                o_state_cdr <= sel_dpath && ev_tap == `TAP_CAP_DR;
                o_state_sdr <= sel_dpath && ev_tap == `TAP_SHIFT_DR;
                o_state_e1dr <= sel_dpath && ev_tap == `TAP_EXIT1_DR;
                o_state_pdr <= sel_dpath && ev_tap == `TAP_PAUSE_DR;
                o_state_e2dr <= sel_dpath && ev_tap == `TAP_EXIT2_DR;
                o_state_udr <= sel_dpath && ev_tap == `TAP_UPD_DR;
                // Instruction-path capture/update ride the physical DR scan
                o_state_cir <= sel_ipath && ev_tap == `TAP_CAP_DR;
                o_state_uir <= sel_ipath && ev_tap == `TAP_UPD_DR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // TDO changes on falling TCK, as the host samples on the rise
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_tdo <= 1'b0;
        else if (tck_fall)
        begin
            if (tap == `TAP_SHIFT_IR)
                o_tdo <= ir_shift[0];
            else if (tap == `TAP_SHIFT_DR && sel_ipath)
                o_tdo <= frame_shift[0];
            else if (tap == `TAP_SHIFT_DR && sel_dpath && active_node != 0)
                o_tdo <= |(i_node_tdo & o_node_enable);
            else if (tap == `TAP_SHIFT_DR)
                o_tdo <= bypass_bit;
        end
    end
endmodule // virtual_scan_hub

// ==== rtl/scan_hub_map.vh ====
`ifndef SCAN_HUB_MAP_VH
`define SCAN_HUB_MAP_VH
// TAP controller states
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1_DR 4'h5
`define TAP_PAUSE_DR 4'h6
`define TAP_EXIT2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'hA
`define TAP_SHIFT_IR 4'hB
`define TAP_EXIT1_IR 4'hC
`define TAP_PAUSE_IR 4'hD
`define TAP_EXIT2_IR 4'hE
`define TAP_UPD_IR 4'hF
// Physical instruction codes, arbitrary defaults
`define IR_LEN 10
`define DATA_PATH_SELECT_CODE 10'h00C
`define INSTRUCTION_PATH_SELECT_CODE 10'h00E
`define IR_CAPTURE 10'h001
// Node address width in the instruction path frame
`define NODE_ADDR_W 8
`define NODE_MAX 255
`endif

// ==== rtl/stage_buffer.v ====
`timescale 1ns/100ps
// Two-entry skid buffer
module stage_buffer #(
    parameter WIDTH = 2
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_valid,
    output wire o_ready,
    input wire [WIDTH-1:0] i_data,
    output wire o_valid,
    input wire i_ready,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem [0:1];
    reg rd_ptr;
    reg wr_ptr;
    reg [1:0] count;
    wire push;
    wire pop;

    assign o_ready = (count != 2'd2);
    assign o_valid = (count != 2'd0);
    assign o_data = mem[rd_ptr];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'd0;
            mem[0] <= {WIDTH{1'b0}};
            mem[1] <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= i_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'd1;
            else if (pop && !push)
                count <= count - 2'd1;
        end
    end
endmodule // stage_buffer

// ==== tb/virtual_scan_hub_monitor.sv ====
`timescale 1ns/100ps
module virtual_scan_hub_monitor #(
    parameter NODES = 4,
    parameter NODE_IW = 4
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_tck,
    input wire [NODES-1:0] o_node_enable,
    input wire [NODES*NODE_IW-1:0] o_node_instruction_out,
    input wire o_tck_rise,
    input wire o_state_cdr,
    input wire o_state_sdr,
    input wire o_state_e1dr,
    input wire o_state_pdr,
    input wire o_state_e2dr,
    input wire o_state_udr,
    input wire o_state_cir,
    input wire o_state_uir
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire [7:0] st = {o_state_cdr, o_state_sdr, o_state_e1dr, o_state_pdr,
        o_state_e2dr, o_state_udr, o_state_cir, o_state_uir};
    ////////////////////////////////////////////////////////////////////////
    one_node_a: assert property ($onehot0(o_node_enable))
        else $error("More than one node enabled");
    one_state_a: assert property ($onehot0(st))
        else $error("State indicators overlap");
    state_hold_a: assert property (!o_tck_rise |-> $stable(st))
        else $error("State moved without a step");
    step_pulse_a: assert property (o_tck_rise |=> !o_tck_rise)
        else $error("Step strobe longer than one cycle");
    step_follow_a: assert property ($rose(i_tck) |-> ##[2:8] o_tck_rise)
        else $error("Test clock rise not followed by a step");
    instr_update_a: assert property ($changed(o_node_instruction_out) |=>
        o_state_uir)
        else $error("Node instruction changed outside update");
    shift_entry_a: assert property ($rose(o_state_sdr) |->
        $past(o_state_cdr || o_state_e2dr))
        else $error("Shift entered from a wrong state");
    update_entry_a: assert property ($rose(o_state_udr) |->
        $past(o_state_e1dr || o_state_e2dr))
        else $error("Update entered from a wrong state");
endmodule // virtual_scan_hub_monitor

bind virtual_scan_hub virtual_scan_hub_monitor #(.NODES(NODES), .NODE_IW(NODE_IW))
    virtual_scan_hub_monitor_inst (.i_clk(i_clk), .i_rst(i_rst), .i_tck(i_tck),
    .o_node_enable(o_node_enable), .o_node_instruction_out(o_node_instruction_out),
    .o_tck_rise(o_tck_rise), .o_state_cdr(o_state_cdr), .o_state_sdr(o_state_sdr),
    .o_state_e1dr(o_state_e1dr), .o_state_pdr(o_state_pdr), .o_state_e2dr(o_state_e2dr),
    .o_state_udr(o_state_udr), .o_state_cir(o_state_cir), .o_state_uir(o_state_uir));

// ==== tb/scan_node_model.sv ====
`timescale 1ns/100ps
module scan_node_model #(
    parameter NODES = 4,
    parameter NODE_IW = 4
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_step,
    input wire i_shift,
    input wire [NODES-1:0] i_enable,
    input wire i_tdi,
    output logic [NODES-1:0] o_tdo,
    output logic [NODES*NODE_IW-1:0] o_ret
);
    logic [1:0] chain [NODES];
    ////////////////////////////////////////////////////////////////////////
    // Private two-bit chain per node, moved only on hub steps
    always @(posedge i_clk or posedge i_rst)
        for (int i = 0; i < NODES; i++)
            if (i_rst)
                chain[i] <= 2'h0;
            else if (i_step && i_shift && i_enable[i])
                chain[i] <= {i_tdi, chain[i][1]};
    // Deselected node shows the inverse so a stale bit cannot pass
    always_comb
        for (int i = 0; i < NODES; i++)
        begin
            o_tdo[i] = i_enable[i] ? chain[i][0] : ~chain[i][0];
            o_ret[i*NODE_IW +: NODE_IW] = NODE_IW'(i + 5);
        end
endmodule // scan_node_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps
`include "scan_hub_map.vh"
module tb;
    localparam NODES = 4;
    localparam NODE_IW = 4;
    logic i_clk = 0, i_rst = 1, i_tck = 0, i_tms = 1, i_tdi = 0, i_trst_n = 1;
    wire o_tdo, o_node_tdi, o_tck_rise, o_state_cdr, o_state_sdr, o_state_e1dr;
    wire o_state_pdr, o_state_e2dr, o_state_udr, o_state_cir, o_state_uir;
    wire [NODES-1:0] i_node_tdo, o_node_enable;
    wire [NODES*NODE_IW-1:0] i_node_instruction_return, o_node_instruction_out;
    int n_errors = 0, num_checks = 0, sdr_seen = 0, cir_seen = 0;
    logic [NODES*NODE_IW-1:0] exp_ins = '0;
    logic [31:0] rd, w;
    virtual_scan_hub #(.NODES(NODES), .NODE_IW(NODE_IW)) virtual_scan_hub_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
        .i_trst_n(i_trst_n), .o_tdo(o_tdo), .i_node_tdo(i_node_tdo),
        .i_node_instruction_return(i_node_instruction_return),
        .o_node_instruction_out(o_node_instruction_out), .o_node_enable(o_node_enable),
        .o_node_tdi(o_node_tdi), .o_tck_rise(o_tck_rise), .o_state_cdr(o_state_cdr),
        .o_state_sdr(o_state_sdr), .o_state_e1dr(o_state_e1dr), .o_state_pdr(o_state_pdr),
        .o_state_e2dr(o_state_e2dr), .o_state_udr(o_state_udr), .o_state_cir(o_state_cir),
        .o_state_uir(o_state_uir));
    scan_node_model #(.NODES(NODES), .NODE_IW(NODE_IW)) scan_node_model_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_step(o_tck_rise), .i_shift(o_state_sdr),
        .i_enable(o_node_enable), .i_tdi(o_node_tdi), .o_tdo(i_node_tdo),
        .o_ret(i_node_instruction_return));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_state_sdr) sdr_seen <= sdr_seen + 1;
    always @(posedge i_clk) if (o_state_cir) cir_seen <= cir_seen + 1;
    // Enable pattern after a frame to address a; zero or out of range selects none
    function automatic logic [31:0] exp_enable(input int a);
        return (a >= 1 && a <= NODES) ? 32'h0000_0001 << (a - 1) : 32'h0000_0000;
    endfunction
    // Frame captured while node p is active: {p, return word of that node model}
    function automatic logic [31:0] exp_frame(input int p);
        logic [NODE_IW-1:0] r;
        r = (p >= 1 && p <= NODES) ? NODE_IW'(p + 4) : '0;
        return 32'({p[7:0], r});
    endfunction
    ////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One test clock period of 16 system clocks; host samples TDO at the rise
    task tck(input logic tms, input logic tdi, output logic tdo);
        @(negedge i_clk);
        i_tms = tms;
        i_tdi = tdi;
        repeat (8) @(negedge i_clk);
        tdo = o_tdo;
        i_tck = 1;
        repeat (7) @(negedge i_clk);
        i_tck = 0;
    endtask
    task tap_reset;
        logic d;
        repeat (5) tck(1, 0, d);
        tck(0, 0, d);
    endtask
    // From idle, through one instruction or data scan, back to idle, LSB first
    task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic d;
        dout = 0;
        tck(1, 0, d);
        if (ir)
            tck(1, 0, d);
        tck(0, 0, d);
        tck(0, 0, d);
        for (int i = 0; i < n; i++)
        begin
            tck(i == n - 1, din[i], d);
            dout[i] = d;
        end
        tck(1, 0, d);
        tck(0, 0, d);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int a, s0, prev;
        logic [3:0] ins;
        logic found;
        void'($urandom(32'h0987));
        repeat (5) @(posedge i_clk);
        @(negedge i_clk) i_rst = 0;
        repeat (4) @(negedge i_clk);
        tap_reset();
        prev = 0;
        // Every node address, plus none and one past the last
        for (a = 0; a <= NODES + 1; a++)
        begin
            ins = (a == 1) ? 4'hF : 4'($urandom);
            scan(1, `IR_LEN, `INSTRUCTION_PATH_SELECT_CODE, rd);
            scan(0, 12, {a[7:0], ins}, rd);
            check(rd[11:0], exp_frame(prev));
            prev = (a >= 1 && a <= NODES) ? a : 0;
            if (a >= 1 && a <= NODES)
                exp_ins[(a-1)*NODE_IW +: NODE_IW] = ins;
            check(o_node_enable, exp_enable(a));
            check(o_node_instruction_out, exp_ins);
        end
        scan(1, `IR_LEN, `INSTRUCTION_PATH_SELECT_CODE, rd);
        check(cir_seen > 0, 1);
        scan(0, 12, {8'h02, ins}, rd);
        check(rd[11:0], exp_frame(prev));
        check(o_node_enable, exp_enable(2));
        scan(1, `IR_LEN, `DATA_PATH_SELECT_CODE, rd);
        w = $urandom;
        s0 = sdr_seen;
        scan(0, 24, {8'h00, w[15:0]}, rd);
        found = 0;
        for (int k = 0; k <= 8; k++)
            if (rd[k +: 16] === w[15:0])
                found = 1;
        check(found, 1);
        check(sdr_seen > s0, 1);
        // Pin reset mid-session drops the data path selection
        @(negedge i_clk) i_trst_n = 0;
        repeat (4) @(negedge i_clk);
        i_trst_n = 1;
        tck(0, 0, found);
        s0 = sdr_seen;
        scan(0, 16, w, rd);
        check(sdr_seen - s0, 0);
        scan(1, `IR_LEN, `DATA_PATH_SELECT_CODE, rd);
        tap_reset();
        s0 = sdr_seen;
        scan(0, 16, w, rd);
        check(sdr_seen - s0, 0);
        results();
    end
    initial
    begin
        repeat (100000) @(posedge i_clk);
        n_errors++;
        results();
    end
endmodule // tb
